/* File: design/mc_pkg.sv */
/*
 Constants, register map and state type of the flash memory checker.
 Assumes one clock domain and word-indexed registers on AXI4-Lite.
*/
package mc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_START = 6'h00;
   localparam logic [5:0] IDX_MODE = 6'h01;
   localparam logic [5:0] IDX_FLAGS = 6'h02;
   localparam logic [5:0] IDX_EVT = 6'h03;
   localparam logic [5:0] IDX_MASK = 6'h04;
   // Field positions
   localparam int EN_BIT = 0;
   localparam int ARM_BIT = 1;
   localparam int BUSY_BIT = 0;
   localparam int OK_BIT = 1;
   localparam int EVT_DONE = 0;
   localparam int EVT_FAIL = 1;
   localparam int MODE_LSB = 4;
   localparam int SEL_LSB = 0;
   // Reset values
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] FLAGS_RST = 8'h02;
   // Field encodings
   localparam logic [1:0] MODE_PRIORITY = 2'h0;
   localparam logic [1:0] MODE_INIT = 2'h1;
   localparam logic [1:0] SEL_FLASH = 2'h0;
   localparam logic [1:0] SEL_BOOTCODE = 2'h1;
   localparam logic [1:0] SEL_BOOT = 2'h2;
   // Timing in clock cycles
   localparam logic [1:0] START_DELAY = 2'h3;
   localparam logic [1:0] FETCH_DIV = 2'h3;
   // CRC
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_RESIDUE = 16'h0000;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      MC_IDLE = 2'b00,
      MC_ARM = 2'b01,
      MC_SCAN = 2'b10,
      MC_CHECK = 2'b11
   } mc_state_t;
endpackage : mc_pkg

/* File: design/mc_crc16.sv */
/*
 Sixteen-bit CRC accumulator, one word per enable, high byte first.
 Assumes clear and enable never coincide with reset release hazards.
*/
`timescale 1ns/100ps
module mc_crc16
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Control and data
   input wire logic clear,
   input wire logic en,
   input wire logic [15:0] data,
   output logic [15:0] crc_q
);
   function automatic logic [15:0] step(input logic [15:0] c,
                                        input logic [15:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 15; i >= 0; i--)
      begin
         if (r[15] ^ d[i])
            r = {r[14:0], 1'b0} ^ mc_pkg::CRC_POLY;
         else
            r = {r[14:0], 1'b0};
      end
      return r;
   endfunction : step

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         crc_q <= mc_pkg::CRC_INIT;
      else if (clear)
         crc_q <= mc_pkg::CRC_INIT;
      else if (en)
         crc_q <= step(crc_q, data);
   end
endmodule : mc_crc16

/* File: design/mc_word_fetch.sv */
/*
 Walks flash word addresses 0..last_addr, one read every third cycle.
 Assumes flash returns read data in the cycle after flash_rd.
*/
`timescale 1ns/100ps
module mc_word_fetch
#(
   parameter int AW = 15
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Control
   input wire logic start,
   input wire logic [AW-1:0] last_addr,
   output logic active_q,
   output logic done_q,
   // Flash port
   output logic flash_rd,
   output logic [AW-1:0] flash_addr_q,
   input wire logic [15:0] flash_rdata,
   // Fetched word
   output logic word_valid_q,
   output logic [15:0] word_q
);
   logic [1:0] div_q;
   logic rd_q;
   logic last_q;

   assign flash_rd = active_q && (div_q == 2'h0);

   // Rate divider
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         div_q <= 2'h0;
      else if (!active_q || div_q == mc_pkg::FETCH_DIV - 2'h1)
         div_q <= 2'h0;
      else
         div_q <= div_q + 2'h1;
   end

   // Address walk
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         active_q <= 1'b0;
         flash_addr_q <= '0;
         last_q <= 1'b0;
      end
      else if (start)
      begin
         active_q <= 1'b1;
         flash_addr_q <= '0;
         last_q <= 1'b0;
      end
      else if (flash_rd)
      begin
         last_q <= (flash_addr_q == last_addr);
         if (flash_addr_q == last_addr)
            active_q <= 1'b0;
         else
            flash_addr_q <= flash_addr_q + 1'b1;
      end
   end

   // Data capture
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_q <= 1'b0;
         word_valid_q <= 1'b0;
         word_q <= 16'h0000;
         done_q <= 1'b0;
      end
      else
      begin
         rd_q <= flash_rd;
         word_valid_q <= rd_q;
         done_q <= rd_q && last_q;
         if (rd_q)
            word_q <= flash_rdata;
      end
   end
endmodule : mc_word_fetch

/* File: design/mc_memory_checker.sv */
/*
 Flash memory checker: AXI4-Lite registers, scan control, CRC compare,
 CPU stall, fatal interrupt and a maskable event interrupt.
 Assumes section ends and start-up straps come from the mclk domain.
*/
// Function
// [R1] Mode register writes ignored while busy or fatal
// [R2] Mode field bits 5:4, zero means priority
// [R3] Start-up scan leaves mode non-zero; software rewrites
// [R4] Section zero checks the whole flash
// [R5] Section one checks boot plus code
// [R6] Section two checks boot only; three reserved
// [R7] Start-up scan section reads back in field
// [R8] Flags register read-only, resets to 0x02
// [R9] Pass flag set by reset, cleared on enable
// [R10] Pass flag reads zero while scan runs
// [R11] Pass flag one means last check matched
// [R12] Busy flag one while running; writes restricted
// [R13] Scan starts three cycles after enable
// [R14] One word every third cycle; CPU stalled
// [R15] Checksum stored last, high byte first
// [R16] Mismatch clears pass, raises sticky fatal interrupt
// [R17] Unused bits read zero, writes ignored
`timescale 1ns/100ps
module mc_memory_checker
#(
   parameter int AW = 15,
   parameter logic [AW-1:0] FLASH_LAST = '1
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // AXI4-Lite write
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // Section ends and start-up configuration
   input wire logic [AW-1:0] boot_last,
   input wire logic [AW-1:0] code_last,
   input wire logic startup_scan,
   input wire logic [1:0] startup_section,
   // Flash and CPU
   output logic flash_rd,
   output logic [AW-1:0] flash_addr,
   input wire logic [15:0] flash_rdata,
   output logic cpu_stall,
   // Interrupts
   output logic fatal_irq,
   output logic irq
);
   mc_pkg::mc_state_t state_q;
   logic [1:0] cnt_q;
   logic [1:0] mode_q;
   logic [1:0] scan_section_select_q;
   logic enable_q;
   logic fatal_irq_arm_q;
   logic ok_q;
   logic nmi_q;
   logic init_q;
   logic [1:0] evt_q;
   logic [1:0] mask_q;
   logic aw_hold_q;
   logic w_hold_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic do_write;
   logic do_read;
   logic wr_lane0;
   logic wr_start;
   logic wr_mode;
   logic wr_mask;
   logic locked;
   logic busy;
   logic start_go;
   logic init_go;
   logic fetch_start;
   logic fetch_done;
   logic word_valid;
   logic [15:0] word;
   logic [15:0] crc;
   logic [AW-1:0] last_addr;
   logic check_ok;
   logic check_fail;
   logic [5:0] rd_idx;
   logic [5:0] wr_idx;
   logic [7:0] flags_rd;
   logic [31:0] rd_mux;
   logic rd_hit;
   logic wr_hit;

   // Bus handshakes
   assign s_awready = !aw_hold_q && !bvalid_q;
   assign s_wready = !w_hold_q && !bvalid_q;
   assign s_arready = !rvalid_q;
   assign s_bvalid = bvalid_q;
   assign s_bresp = bresp_q;
   assign s_rvalid = rvalid_q;
   assign s_rdata = rdata_q;
   assign s_rresp = rresp_q;
   assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
   assign do_read = s_arvalid && !rvalid_q;
   assign wr_idx = awaddr_q[7:2];
   assign rd_idx = s_araddr[7:2];
   assign wr_lane0 = do_write && wstrb_q[0];

   // Status and lock
   assign busy = (state_q == mc_pkg::MC_SCAN) ||
                 (state_q == mc_pkg::MC_CHECK); // R12
   assign locked = (state_q != mc_pkg::MC_IDLE) || nmi_q; // R1 R12
   assign cpu_stall = busy; // R14
   assign fatal_irq = nmi_q;
   assign irq = |(evt_q & mask_q);
   assign wr_start = wr_lane0 && (wr_idx == mc_pkg::IDX_START) && !locked;
   assign wr_mode = wr_lane0 && (wr_idx == mc_pkg::IDX_MODE) && !locked;
   assign wr_mask = wr_lane0 && (wr_idx == mc_pkg::IDX_MASK);
   assign start_go = wr_start && wdata_q[mc_pkg::EN_BIT];
   assign init_go = !init_q && startup_scan;

   // Write channel capture
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_hold_q <= 1'b0;
         awaddr_q <= 8'h00;
      end
      else if (s_awvalid && s_awready)
      begin
         aw_hold_q <= 1'b1;
         awaddr_q <= s_awaddr;
      end
      else if (do_write)
         aw_hold_q <= 1'b0;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         w_hold_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end
      else if (s_wvalid && s_wready)
      begin
         w_hold_q <= 1'b1;
         wdata_q <= s_wdata;
         wstrb_q <= s_wstrb;
      end
      else if (do_write)
         w_hold_q <= 1'b0;
   end

   always_comb
   begin
      case (wr_idx)
         mc_pkg::IDX_START, mc_pkg::IDX_MODE, mc_pkg::IDX_FLAGS,
         mc_pkg::IDX_EVT, mc_pkg::IDX_MASK:
            wr_hit = 1'b1;
         default:
            wr_hit = 1'b0;
      endcase
   end

   // Write response
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bvalid_q <= 1'b0;
         bresp_q <= mc_pkg::RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? mc_pkg::RESP_OKAY : mc_pkg::RESP_SLVERR;
      end
      else if (s_bready)
         bvalid_q <= 1'b0;
   end

   // Read data
   assign flags_rd = {6'h00, ok_q && !busy, busy}; // R8 R10 R17

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      case (rd_idx)
         mc_pkg::IDX_START:
            rd_mux[1:0] = {fatal_irq_arm_q, enable_q};
         mc_pkg::IDX_MODE:
         begin
            rd_mux[mc_pkg::MODE_LSB +: 2] = mode_q; // R2 R3
            rd_mux[mc_pkg::SEL_LSB +: 2] = scan_section_select_q; // R7
         end
         mc_pkg::IDX_FLAGS:
            rd_mux[7:0] = flags_rd;
         mc_pkg::IDX_EVT:
            rd_mux[1:0] = evt_q;
         mc_pkg::IDX_MASK:
            rd_mux[1:0] = mask_q;
         default:
            rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= mc_pkg::RESP_OKAY;
      end
      else if (do_read)
      begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= rd_hit ? mc_pkg::RESP_OKAY : mc_pkg::RESP_SLVERR;
      end
      else if (s_rready)
         rvalid_q <= 1'b0;
   end

   // Start-up scan capture after reset release
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         init_q <= 1'b0;
      else
         init_q <= 1'b1;
   end

   // Mode and section
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_q <= mc_pkg::MODE_RST[mc_pkg::MODE_LSB +: 2];
         scan_section_select_q <= mc_pkg::MODE_RST[mc_pkg::SEL_LSB +: 2];
      end
      else if (init_go)
      begin
         mode_q <= mc_pkg::MODE_INIT; // R3
         scan_section_select_q <= startup_section; // R7
      end
      else if (wr_mode) // R1 R17
      begin
         mode_q <= wdata_q[mc_pkg::MODE_LSB +: 2]; // R2
         scan_section_select_q <= wdata_q[mc_pkg::SEL_LSB +: 2];
      end
   end

   // Enable and arming
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         enable_q <= 1'b0;
         fatal_irq_arm_q <= 1'b0;
      end
      else if (init_go)
         enable_q <= 1'b1;
      else if (wr_start)
      begin
         enable_q <= wdata_q[mc_pkg::EN_BIT];
         if (wdata_q[mc_pkg::ARM_BIT])
            fatal_irq_arm_q <= 1'b1;
      end
   end

   // Section end select
   always_comb
   begin
      case (scan_section_select_q)
         mc_pkg::SEL_FLASH:
            last_addr = FLASH_LAST; // R4
         mc_pkg::SEL_BOOTCODE:
            last_addr = code_last; // R5
         mc_pkg::SEL_BOOT:
            last_addr = boot_last; // R6
         default:
            last_addr = boot_last;
      endcase
   end

   // Sequencer
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= mc_pkg::MC_IDLE;
         cnt_q <= 2'h0;
      end
      else
      begin
         case (state_q)
            mc_pkg::MC_IDLE:
            begin
               cnt_q <= 2'h0;
               if (init_go)
                  state_q <= mc_pkg::MC_SCAN;
               else if (start_go)
                  state_q <= mc_pkg::MC_ARM;
            end
            mc_pkg::MC_ARM:
            begin
               cnt_q <= cnt_q + 2'h1;
               if (cnt_q == mc_pkg::START_DELAY - 2'h2) // R13
                  state_q <= mc_pkg::MC_SCAN;
            end
            mc_pkg::MC_SCAN:
               if (fetch_done)
                  state_q <= mc_pkg::MC_CHECK;
            mc_pkg::MC_CHECK:
               state_q <= mc_pkg::MC_IDLE;
            default:
               state_q <= mc_pkg::MC_IDLE;
         endcase
      end
   end

   assign fetch_start = (state_q == mc_pkg::MC_ARM &&
                         cnt_q == mc_pkg::START_DELAY - 2'h2) || init_go;
   // Appended checksum drives the residue to zero
   assign check_ok = (state_q == mc_pkg::MC_CHECK) &&
                     (crc == mc_pkg::CRC_RESIDUE); // R15
   assign check_fail = (state_q == mc_pkg::MC_CHECK) &&
                       (crc != mc_pkg::CRC_RESIDUE);

   // Pass flag
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         ok_q <= mc_pkg::FLAGS_RST[mc_pkg::OK_BIT]; // R9
      else if (start_go || init_go)
         ok_q <= 1'b0; // R9
      else if (check_ok)
         ok_q <= 1'b1; // R11
      else if (check_fail)
         ok_q <= 1'b0; // R16
   end

   // Fatal interrupt held until reset
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         nmi_q <= 1'b0;
      else if (check_fail && fatal_irq_arm_q)
         nmi_q <= 1'b1; // R16
   end

   // Events, read of the event register clears, set wins
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         evt_q <= 2'h0;
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if ((i == mc_pkg::EVT_DONE && (check_ok || check_fail)) ||
                (i == mc_pkg::EVT_FAIL && check_fail))
               evt_q[i] <= 1'b1;
            else if (do_read && rd_idx == mc_pkg::IDX_EVT)
               evt_q[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         mask_q <= 2'h0;
      else if (wr_mask)
         mask_q <= wdata_q[1:0];
   end

   mc_word_fetch #(
      .AW(AW)
   ) u_fetch (
      .mclk(mclk),
      .rst_n(rst_n),
      .start(fetch_start),
      .last_addr(last_addr),
      .active_q(),
      .done_q(fetch_done),
      .flash_rd(flash_rd), // R14
      .flash_addr_q(flash_addr),
      .flash_rdata(flash_rdata),
      .word_valid_q(word_valid),
      .word_q(word)
   );

   mc_crc16 u_crc (
      .mclk(mclk),
      .rst_n(rst_n),
      .clear(fetch_start),
      .en(word_valid),
      .data(word),
      .crc_q(crc)
   );

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence quiet_two_s;
      !busy ##1 !busy;
   endsequence

   start_delay_a: assert property (start_go |=> quiet_two_s ##1 busy) // R13
      else $error("scan did not start three cycles after enable");
   ok_busy_a: assert property (busy |-> // R10
      !ok_q && !flags_rd[mc_pkg::OK_BIT])
      else $error("pass flag visible while busy");
   ok_clear_a: assert property (start_go |=> !ok_q) // R9
      else $error("pass flag not cleared on enable");
   mode_lock_a: assert property ((do_write && locked) |=> // R1
      $stable(mode_q) && $stable(scan_section_select_q))
      else $error("mode register changed while locked");
   fetch_rate_a: assert property (flash_rd |=> !flash_rd ##1 !flash_rd) // R14
      else $error("flash fetched faster than every third cycle");
   match_ok_a: assert property (check_ok |=> ok_q && !busy) // R11
      else $error("matched check did not set pass");
   fatal_hold_a: assert property ((check_fail && fatal_irq_arm_q) |=> // R16
      fatal_irq[*4])
      else $error("fatal interrupt not raised and held");
   reserved_zero_a: assert property (s_rvalid |-> s_rdata[31:8] == 24'h0) // R17
      else $error("reserved read bits not zero");
   stall_scan_a: assert property ($rose(busy) |-> cpu_stall && flash_rd) // R14
      else $error("cpu not stalled or not fetching at scan start");
endmodule : mc_memory_checker

/* File: verification/mc_flash_model.sv */
/*
 Behavioural program flash answering the memory checker's word reads.
 Assumes the bench loads mem, checksum words included, before a scan.
*/
`timescale 1ns/100ps
module mc_flash_model
#(
   parameter int AW = 15,
   parameter int DEPTH = 32
)
(
   // Clock
   input wire logic mclk,
   // Read port
   input wire logic flash_rd,
   input wire logic [AW-1:0] flash_addr,
   output logic [15:0] flash_rdata
);
   // Checksum word sits last in a section, high byte in [15:8]
   logic [15:0] mem [DEPTH];
   initial flash_rdata = 16'h0000;
   // Data valid the cycle after a read, churning otherwise
   always @(posedge mclk)
   begin
      if (flash_rd && (flash_addr < DEPTH))
         flash_rdata <= mem[flash_addr];
      else
         flash_rdata <= ~flash_rdata;
   end
endmodule : mc_flash_model

/* File: verification/tb_top.sv */
/*
 Self-checking bench for the memory checker over AXI4-Lite.
 Assumes the flash model beside it and the designer's bus timing.
*/
`timescale 1ns/100ps
module tb_top;
   localparam int AW = 15;
   localparam logic [AW-1:0] L_ALL = 15'h001f;
   localparam logic [AW-1:0] L_CODE = 15'h000f;
   localparam logic [AW-1:0] L_BOOT = 15'h0007;
   localparam logic [7:0] A_START = {mc_pkg::IDX_START, 2'b00};
   localparam logic [7:0] A_MODE = {mc_pkg::IDX_MODE, 2'b00};
   localparam logic [7:0] A_FLAGS = {mc_pkg::IDX_FLAGS, 2'b00};
   localparam logic [7:0] A_EVT = {mc_pkg::IDX_EVT, 2'b00};
   localparam logic [7:0] A_MASK = {mc_pkg::IDX_MASK, 2'b00};
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] s_awaddr = 8'h00;
   logic [7:0] s_araddr = 8'h00;
   logic [31:0] s_wdata = 32'h0;
   logic [3:0] s_wstrb = 4'h0;
   logic s_awvalid = 1'b0;
   logic s_wvalid = 1'b0;
   logic s_bready = 1'b0;
   logic s_arvalid = 1'b0;
   logic s_rready = 1'b0;
   logic startup_scan = 1'b0;
   logic [1:0] startup_section = 2'h0;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0] s_bresp, s_rresp, resp_q;
   logic [31:0] s_rdata, rd_q;
   logic flash_rd, cpu_stall, fatal_irq, irq;
   logic [AW-1:0] flash_addr;
   logic [15:0] flash_rdata;
   logic stall_prev = 1'b0;
   int errors = 0;
   int comparisons = 0;
   int cyc = 0;
   int t_take = 0;
   int rise_cyc = 0;
   int last_rd = 0;
   int nrd = 0;

   always #25 mclk = ~mclk;

   mc_memory_checker #(.AW(AW), .FLASH_LAST(L_ALL)) i_dut (.mclk(mclk),
      .rst_n(rst_n), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
      .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
      .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
      .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
      .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
      .boot_last(L_BOOT), .code_last(L_CODE),
      .startup_scan(startup_scan), .startup_section(startup_section),
      .flash_rd(flash_rd), .flash_addr(flash_addr),
      .flash_rdata(flash_rdata), .cpu_stall(cpu_stall),
      .fatal_irq(fatal_irq), .irq(irq));

   mc_flash_model #(.AW(AW), .DEPTH(32)) i_flash (.mclk(mclk),
      .flash_rd(flash_rd), .flash_addr(flash_addr),
      .flash_rdata(flash_rdata));

   task automatic wrap_up();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up

   task automatic check_reg(input string what, input logic [31:0] exp,
                            input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check_reg

   task automatic check_sig(input string what, input logic exp,
                            input logic got);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask : check_sig

   task automatic hang();
      errors++;
      $display("[FAIL] wait expected done seen timeout");
      wrap_up();
   endtask : hang

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      bit aw_ok;
      bit w_ok;
      int n;
      aw_ok = 0;
      w_ok = 0;
      n = 0;
      @(posedge mclk);
      s_awaddr <= a;
      s_awvalid <= 1'b1;
      s_wdata <= d;
      s_wstrb <= 4'hf;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge mclk);
         n++;
         if (n > 100)
            hang();
         if (!aw_ok && s_awready === 1'b1)
         begin
            aw_ok = 1;
            s_awvalid <= 1'b0;
         end
         if (!w_ok && s_wready === 1'b1)
         begin
            w_ok = 1;
            s_wvalid <= 1'b0;
         end
         // Write lands in the cycle after both halves are taken
         t_take = cyc + 1;
      end
      do
      begin
         @(posedge mclk);
         n++;
         if (n > 100)
            hang();
      end while (s_bvalid !== 1'b1);
      resp_q = s_bresp;
      s_bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge mclk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
         if (n > 100)
            hang();
      end while (s_arready !== 1'b1);
      s_arvalid <= 1'b0;
      while (s_rvalid !== 1'b1)
      begin
         @(posedge mclk);
         n++;
         if (n > 100)
            hang();
      end
      rd_q = s_rdata;
      resp_q = s_rresp;
      s_rready <= 1'b0;
   endtask : axi_rd

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                         input string what);
      axi_rd(a);
      check_reg(what, exp, rd_q);
      check_reg("read resp", {30'h0, mc_pkg::RESP_OKAY}, {30'h0, resp_q});
   endtask : rd_chk

   task automatic wait_idle();
      int n;
      repeat (4) @(negedge mclk);
      for (n = 0; cpu_stall !== 1'b0; n++)
      begin
         if (n > 3000)
            hang();
         @(negedge mclk);
      end
   endtask : wait_idle

   function automatic logic [15:0] crc_words(input int n);
      logic [15:0] c;
      logic fb;
      c = mc_pkg::CRC_INIT;
      for (int k = 0; k < n; k++)
         for (int b = 15; b >= 0; b--)
         begin
            fb = c[15] ^ i_flash.mem[k][b];
            c = {c[14:0], 1'b0} ^ (fb ? mc_pkg::CRC_POLY : 16'h0000);
         end
      return c;
   endfunction : crc_words

   // Fetch address, spacing and stall watch
   always @(negedge mclk)
   begin
      cyc = cyc + 1;
      if (cpu_stall === 1'b1 && stall_prev !== 1'b1)
         rise_cyc = cyc;
      stall_prev = cpu_stall;
      if (flash_rd === 1'b1)
      begin
         check_reg("flash addr", 32'(nrd), {17'h0, flash_addr});
         check_sig("stall at fetch", 1'b1, cpu_stall);
         if (last_rd != 0)
            check_reg("fetch gap", 32'd3, 32'(cyc - last_rd));
         last_rd = cyc;
         nrd++;
      end
   end

   task automatic run_scan(input logic [1:0] sect, input logic [7:0] msk,
                           input logic [AW-1:0] last);
      int t_en;
      axi_wr(A_MODE, {30'h0, sect});
      axi_wr(A_MASK, {24'h0, msk});
      nrd = 0;
      last_rd = 0;
      axi_wr(A_START, 32'h1);
      t_en = t_take;
      repeat (4) @(posedge mclk);
      rd_chk(A_FLAGS, 32'h1, "flags busy");
      axi_wr(A_MODE, 32'h3);
      wait_idle();
      check_reg("start delay", 32'd3, 32'(rise_cyc - t_en));
      check_reg("fetch count", 32'(last) + 32'd1, 32'(nrd));
      rd_chk(A_MODE, {30'h0, sect}, "mode locked");
      rd_chk(A_FLAGS, 32'h2, "flags pass");
      check_sig("irq done", msk[0], irq);
      rd_chk(A_EVT, 32'h1, "evt done");
      check_sig("irq cleared", 1'b0, irq);
   endtask : run_scan

   initial
   begin
      for (int k = 0; k < 32; k++)
         i_flash.mem[k] = 16'h1000 + 16'(k * 37);
      i_flash.mem[7] = crc_words(7);
      i_flash.mem[15] = crc_words(15);
      i_flash.mem[31] = crc_words(31);
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      rd_chk(A_FLAGS, {24'h0, mc_pkg::FLAGS_RST}, "flags reset");
      rd_chk(A_MODE, {24'h0, mc_pkg::MODE_RST}, "mode reset");
      axi_wr(A_FLAGS, 32'h0);
      check_reg("flags wr resp", 32'h0, {30'h0, resp_q});
      rd_chk(A_FLAGS, 32'h2, "flags read only");
      axi_wr(A_MODE, 32'hffff_ffff);
      rd_chk(A_MODE, 32'h33, "mode unused bits");
      axi_rd(8'h20);
      check_reg("unmapped resp", 32'h2, {30'h0, resp_q});
      axi_wr(8'h20, 32'h1);
      check_reg("unmapped wr resp", 32'h2, {30'h0, resp_q});
      $display("test register_map done");
      run_scan(mc_pkg::SEL_FLASH, 8'h00, L_ALL);
      run_scan(mc_pkg::SEL_BOOTCODE, 8'h01, L_CODE);
      run_scan(mc_pkg::SEL_BOOT, 8'h01, L_BOOT);
      $display("test sections done");
      i_flash.mem[3] = ~i_flash.mem[3];
      axi_wr(A_MODE, {30'h0, mc_pkg::SEL_BOOT});
      axi_wr(A_MASK, 32'h2);
      nrd = 0;
      last_rd = 0;
      axi_wr(A_START, 32'h3);
      wait_idle();
      rd_chk(A_FLAGS, 32'h0, "flags fail");
      check_sig("fatal irq", 1'b1, fatal_irq);
      check_sig("irq fail", 1'b1, irq);
      rd_chk(A_EVT, 32'h3, "evt fail");
      axi_wr(A_MODE, 32'h1);
      rd_chk(A_MODE, {30'h0, mc_pkg::SEL_BOOT}, "mode after fatal");
      nrd = 0;
      axi_wr(A_START, 32'h1);
      repeat (6) @(negedge mclk);
      check_sig("no rescan", 1'b0, cpu_stall);
      check_reg("no fetch", 32'h0, 32'(nrd));
      $display("test failure done");
      i_flash.mem[3] = ~i_flash.mem[3];
      @(posedge mclk);
      rst_n <= 1'b0;
      startup_scan <= 1'b1;
      startup_section <= mc_pkg::SEL_BOOTCODE;
      nrd = 0;
      last_rd = 0;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      wait_idle();
      check_sig("fatal cleared", 1'b0, fatal_irq);
      check_reg("startup fetches", 32'(L_CODE) + 32'd1, 32'(nrd));
      rd_chk(A_MODE, {24'h0, 2'b00, mc_pkg::MODE_INIT, 2'b00,
             mc_pkg::SEL_BOOTCODE}, "mode startup");
      axi_wr(A_MODE, 32'h0);
      rd_chk(A_MODE, 32'h0, "mode rewrite");
      rd_chk(A_FLAGS, 32'h2, "startup pass");
      $display("test startup done");
      wrap_up();
   end
endmodule : tb_top
